// file: rtl/usb_frame_pkg.sv
package usb_frame_pkg;
	// Register offsets (byte addresses on the peripheral port)
	localparam logic [7:0]  OFF_OTG_FLAGS = 8'h14;
	localparam logic [7:0]  OFF_SERIAL    = 8'h18;
	localparam logic [7:0]  OFF_FLAGS     = 8'h1c;
	localparam logic [7:0]  OFF_HOLD      = 8'h20;
	localparam logic [7:0]  OFF_MASKS     = 8'h24;
	localparam logic [7:0]  OFF_FRAME     = 8'h28;
	localparam logic [7:0]  OFF_PID       = 8'h2c;
	localparam logic [7:0]  OFF_EP        = 8'h30;
	localparam logic [7:0]  OFF_EP_MARK   = 8'h34;
	localparam logic [7:0]  OFF_OTG_MASK  = 8'h38;

	// Line-event flag positions
	localparam int          NUM_FLAGS     = 7;
	localparam int          FLAG_TOKEN    = 6;
	localparam int          FLAG_SE0      = 5;
	localparam int          FLAG_K        = 4;
	localparam int          FLAG_J        = 3;
	localparam int          FLAG_CRC16    = 2;
	localparam int          FLAG_RXACT    = 1;
	localparam int          FLAG_RXERR    = 0;
	// Flags raised by one-cycle events rather than following a level
	localparam logic [6:0]  FLAG_PULSE    = 7'h44;

	// Serial control field positions and reset value of the writable bits
	localparam int          SER_RXRCV     = 6;
	localparam int          SER_RXDM      = 5;
	localparam int          SER_RXDP      = 4;
	localparam int          SER_TXSE0     = 3;
	localparam int          SER_TXDATA    = 2;
	localparam int          SER_TXEN_N    = 1;
	localparam int          SER_FSLS      = 0;
	localparam logic [3:0]  SER_RESET     = 4'h2;

	// Event port masks
	localparam int          NUM_PORTS     = 4;
	localparam int          MASK_W        = 8;

	// Frame number, endpoint and packet fields
	localparam int          FRAME_W       = 11;
	localparam int          EP_VALID_BIT  = 4;
	localparam logic [4:0]  EP_MARK       = 5'h10;
	localparam logic [6:0]  DEV_ADDR_RST  = 7'h00;

	// Decoded line state codes
	localparam logic [1:0]  LS_SE0        = 2'h0;
	localparam logic [1:0]  LS_J          = 2'h1;
	localparam logic [1:0]  LS_K          = 2'h2;

	// Token identification and CRC5
	localparam logic [3:0]  PID_SOF       = 4'h5;
	localparam logic [1:0]  PID_TOKEN_LO  = 2'h1;
	localparam logic [4:0]  CRC5_POLY     = 5'h05;
	localparam logic [4:0]  CRC5_INIT     = 5'h1f;

	// Width of the synchronised transceiver status bundle
	localparam int          SYNC_W        = 13;
endpackage

// file: rtl/pin_sync3.sv
`timescale 1ns/1ps
module pin_sync3 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Asynchronous pins in, settled values out
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_out
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] out_r;
	logic [W-1:0] out_nxt;

	// A bit changes only once stages two and three agree
	always_comb begin
		for (int i = 0; i < W; i++) begin
			out_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : out_r[i];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_r  <= '0;
			s2_r  <= '0;
			s3_r  <= '0;
			out_r <= '0;
		end else begin
			s1_r  <= pin_in;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			out_r <= out_nxt;
		end
	end

	assign pin_out = out_r;
endmodule

// file: rtl/token_check.sv
`timescale 1ns/1ps
module token_check
	import usb_frame_pkg::*;
(
	// Token as received
	input  wire logic [7:0]  pid_byte,
	input  wire logic [15:0] body,
	input  wire logic [6:0]  dev_addr,
	// Verdicts
	output logic             crc_ok,
	output logic             pid_ok,
	output logic             is_token,
	output logic             is_sof,
	output logic             addr_hit
);
	logic [4:0] crc;
	logic [4:0] expect_crc;
	logic       fb;

	// CRC5 over address and endpoint, least significant bit first
	always_comb begin
		crc = CRC5_INIT;
		fb  = 1'b0;
		for (int i = 0; i < FRAME_W; i++) begin
			fb  = body[i] ^ crc[4];
			crc = {crc[3:0], 1'b0} ^ (fb ? CRC5_POLY : 5'h00);
		end
		for (int j = 0; j < 5; j++) begin
			expect_crc[j] = ~crc[4-j];
		end
	end

	assign crc_ok   = (body[15:11] == expect_crc);
	assign pid_ok   = (pid_byte[7:4] == ~pid_byte[3:0]);
	assign is_token = (pid_byte[1:0] == PID_TOKEN_LO);
	assign is_sof   = (pid_byte[3:0] == PID_SOF);
	assign addr_hit = (body[6:0] == dev_addr);
endmodule

// file: rtl/usb_phy_flag_monitor.sv
`timescale 1ns/1ps
module usb_phy_flag_monitor
	import usb_frame_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Peripheral register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	// Transceiver status pins
	input  wire logic        utmi_bvalid,
	input  wire logic        utmi_idgnd,
	input  wire logic        utmi_hostdis,
	input  wire logic        utmi_vbusvld,
	input  wire logic        utmi_sessvld,
	input  wire logic        utmi_sessend,
	input  wire logic        utmi_rxrcv,
	input  wire logic        utmi_rxdm,
	input  wire logic        utmi_rxdp,
	input  wire logic [1:0]  utmi_linestate,
	input  wire logic        utmi_rxactive,
	input  wire logic        utmi_rxerror,
	// Serial line drive
	output logic             tx_se0,
	output logic             tx_data,
	output logic             tx_enable_n,
	output logic             fsls_serial,
	// Packet decoder, same clock
	input  wire logic        pkt_start,
	input  wire logic [3:0]  pkt_pid,
	input  wire logic        tok_valid,
	input  wire logic [7:0]  tok_pid,
	input  wire logic [15:0] tok_body,
	input  wire logic        data_crc_err,
	input  wire logic [6:0]  dev_addr,
	// Event ports
	output logic             event_port_a,
	output logic             event_port_b,
	output logic             event_port_c,
	output logic             event_port_d,
	// Receive endpoint port
	output logic      [4:0]  rx_ep,
	output logic             rx_ep_valid
);
	logic [SYNC_W-1:0]  sync_out;
	logic [5:0]         otg_s;
	logic [2:0]         rxl_s;
	logic [1:0]         ls_s;
	logic               rxact_s;
	logic               rxerr_s;

	logic               crc_ok;
	logic               pid_ok;
	logic               is_token;
	logic               is_sof;
	logic               addr_hit;
	logic               tok_accept;
	logic               sof_ok;

	logic [6:0]         flags_r, flags_nxt;
	logic [6:0]         hold_r, hold_nxt;
	logic [31:0]        masks_r, masks_nxt;
	logic [3:0]         ser_r, ser_nxt;
	logic [FRAME_W-1:0] frame_r, frame_nxt;
	logic [3:0]         pid_r, pid_nxt;
	logic [4:0]         ep_r, ep_nxt;
	logic [15:0]        mark_r, mark_nxt;
	logic [31:0]        otg_mask_r, otg_mask_nxt;
	logic [4:0]         rx_ep_r, rx_ep_nxt;
	logic               rx_ep_valid_r, rx_ep_valid_nxt;
	logic [31:0]        rdata_r, rdata_nxt;
	logic [6:0]         ev;
	logic [6:0]         clr;
	logic [NUM_PORTS-1:0] port_hit;
	logic               wr_at_flags;

	pin_sync3 #(.W(SYNC_W)) u_sync (
		.clk     (clk),
		.rst     (rst),
		.pin_in  ({utmi_bvalid, utmi_idgnd, utmi_hostdis, utmi_vbusvld,
			   utmi_sessvld, utmi_sessend, utmi_rxrcv, utmi_rxdm, utmi_rxdp,
			   utmi_linestate, utmi_rxactive, utmi_rxerror}),
		.pin_out (sync_out)
	);

	assign otg_s   = sync_out[12:7];
	assign rxl_s   = sync_out[6:4];
	assign ls_s    = sync_out[3:2];
	assign rxact_s = sync_out[1];
	assign rxerr_s = sync_out[0];

	token_check u_tok (
		.pid_byte (tok_pid),
		.body     (tok_body),
		.dev_addr (dev_addr),
		.crc_ok   (crc_ok),
		.pid_ok   (pid_ok),
		.is_token (is_token),
		.is_sof   (is_sof),
		.addr_hit (addr_hit)
	);

	// Start-of-frame carries no address, so it bypasses the address check
	assign tok_accept = tok_valid & crc_ok & pid_ok & is_token & ~is_sof & addr_hit;
	assign sof_ok     = tok_valid & crc_ok & pid_ok & is_sof;

	assign wr_at_flags = reg_wr & (reg_addr == OFF_FLAGS);
	assign clr         = wr_at_flags ? reg_wdata[6:0] : 7'h00;

	always_comb begin
		ev[FLAG_TOKEN] = tok_accept;
		ev[FLAG_SE0]   = (ls_s == LS_SE0);
		ev[FLAG_K]     = (ls_s == LS_K);
		ev[FLAG_J]     = (ls_s == LS_J);
		ev[FLAG_CRC16] = data_crc_err;
		ev[FLAG_RXACT] = rxact_s;
		ev[FLAG_RXERR] = rxerr_s;
	end

	// A new event always wins over a clear in the same cycle
	always_comb begin
		for (int i = 0; i < NUM_FLAGS; i++) begin
			if (hold_r[i]) begin
				flags_nxt[i] = ev[i] | (flags_r[i] & ~clr[i]);
			end else if (FLAG_PULSE[i]) begin
				flags_nxt[i] = ev[i] | (flags_r[i] & ~clr[i] & ~pkt_start);
			end else begin
				flags_nxt[i] = ev[i];
			end
		end
	end

	always_comb begin
		hold_nxt     = hold_r;
		masks_nxt    = masks_r;
		ser_nxt      = ser_r;
		frame_nxt    = frame_r;
		mark_nxt     = mark_r;
		otg_mask_nxt = otg_mask_r;
		if (reg_wr) begin
			unique case (reg_addr)
				OFF_HOLD:     hold_nxt     = reg_wdata[6:0];
				OFF_MASKS:    masks_nxt    = reg_wdata;
				OFF_SERIAL:   ser_nxt      = reg_wdata[3:0];
				OFF_FRAME:    frame_nxt    = reg_wdata[FRAME_W-1:0];
				OFF_EP_MARK:  mark_nxt     = reg_wdata[15:0];
				OFF_OTG_MASK: otg_mask_nxt = reg_wdata;
				default:      ;
			endcase
		end
		// The frame number seen on the wire overrides a software write
		if (sof_ok) begin
			frame_nxt = tok_body[FRAME_W-1:0];
		end
	end

	always_comb begin
		pid_nxt         = pkt_start ? pkt_pid : pid_r;
		ep_nxt          = ep_r;
		rx_ep_nxt       = rx_ep_r;
		rx_ep_valid_nxt = tok_accept;
		if (tok_accept) begin
			ep_nxt    = {1'b1, tok_body[10:7]};
			rx_ep_nxt = {1'b0, tok_body[10:7]} |
				    (mark_r[tok_body[10:7]] ? EP_MARK : 5'h00);
		end
	end

	// Read data is registered; unmapped and reserved bits read zero
	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_rd) begin
			unique case (reg_addr)
				OFF_OTG_FLAGS: rdata_nxt = {26'h0, otg_s};
				OFF_SERIAL:    rdata_nxt = {25'h0, rxl_s, ser_r};
				OFF_FLAGS:     rdata_nxt = {25'h0, flags_r};
				OFF_HOLD:      rdata_nxt = {25'h0, hold_r};
				OFF_MASKS:     rdata_nxt = masks_r;
				OFF_FRAME:     rdata_nxt = {21'h0, frame_r};
				OFF_PID:       rdata_nxt = {28'h0, pid_r};
				OFF_EP:        rdata_nxt = {27'h0, ep_r};
				OFF_EP_MARK:   rdata_nxt = {16'h0, mark_r};
				OFF_OTG_MASK:  rdata_nxt = otg_mask_r;
				default:       rdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			flags_r       <= 7'h00;
			hold_r        <= 7'h00;
			masks_r       <= 32'h0;
			ser_r         <= SER_RESET;
			frame_r       <= 11'h000;
			pid_r         <= 4'h0;
			ep_r          <= 5'h00;
			mark_r        <= 16'h0;
			otg_mask_r    <= 32'h0;
			rx_ep_r       <= 5'h00;
			rx_ep_valid_r <= 1'b0;
			rdata_r       <= 32'h0;
		end else begin
			flags_r       <= flags_nxt;
			hold_r        <= hold_nxt;
			masks_r       <= masks_nxt;
			ser_r         <= ser_nxt;
			frame_r       <= frame_nxt;
			pid_r         <= pid_nxt;
			ep_r          <= ep_nxt;
			mark_r        <= mark_nxt;
			otg_mask_r    <= otg_mask_nxt;
			rx_ep_r       <= rx_ep_nxt;
			rx_ep_valid_r <= rx_ep_valid_nxt;
			rdata_r       <= rdata_nxt;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_PORTS; g++) begin : g_port
			assign port_hit[g] = |(flags_r & masks_r[g*MASK_W +: NUM_FLAGS]);
		end
	endgenerate

	assign event_port_a = port_hit[0];
	assign event_port_b = port_hit[1];
	assign event_port_c = port_hit[2];
	assign event_port_d = port_hit[3];

	assign tx_se0      = ser_r[SER_TXSE0];
	assign tx_data     = ser_r[SER_TXDATA];
	assign tx_enable_n = ser_r[SER_TXEN_N];
	assign fsls_serial = ser_r[SER_FSLS];
	assign rx_ep       = rx_ep_r;
	assign rx_ep_valid = rx_ep_valid_r;
	assign reg_rdata   = rdata_r;

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	logic [6:0] kept;
	assign kept = flags_r & hold_r & ~clr;

	property p_otg_read;
		reg_rd && reg_addr == OFF_OTG_FLAGS |=> reg_rdata == {26'h0, $past(otg_s)};
	endproperty
	a_otg_read: assert property (p_otg_read) else $error("otg flags read wrong");

	property p_serial_read;
		reg_rd && reg_addr == OFF_SERIAL |=> reg_rdata[6:4] == $past(rxl_s);
	endproperty
	a_serial_read: assert property (p_serial_read) else $error("rx lines read wrong");

	property p_tx_drive;
		reg_wr && reg_addr == OFF_SERIAL |=>
			tx_se0 == $past(reg_wdata[3]) && tx_data == $past(reg_wdata[2]);
	endproperty
	a_tx_drive: assert property (p_tx_drive) else $error("tx drive not written");

	property p_tx_en;
		reg_wr && reg_addr == OFF_SERIAL && !reg_wdata[1] |=> !tx_enable_n ##1 1;
	endproperty
	a_tx_en: assert property (p_tx_en) else $error("tx enable not asserted");

	property p_fsls;
		reg_wr && reg_addr == OFF_SERIAL |=> fsls_serial == $past(reg_wdata[0]);
	endproperty
	a_fsls: assert property (p_fsls) else $error("serial mode not written");

	property p_auto_clear;
		pkt_start && !hold_r[FLAG_TOKEN] && !tok_accept |=> !flags_r[FLAG_TOKEN];
	endproperty
	a_auto_clear: assert property (p_auto_clear) else $error("token flag not cleared");

	property p_token_flag;
		tok_accept |=> flags_r[FLAG_TOKEN] && rx_ep_valid;
	endproperty
	a_token_flag: assert property (p_token_flag) else $error("token not flagged");

	property p_se0;
		ls_s == LS_SE0 |=> flags_r[FLAG_SE0] && !flags_r[FLAG_J] || hold_r[FLAG_J];
	endproperty
	a_se0: assert property (p_se0) else $error("se0 flag wrong");

	property p_crc16;
		data_crc_err |=> flags_r[FLAG_CRC16];
	endproperty
	a_crc16: assert property (p_crc16) else $error("crc16 flag missing");

	property p_rxact;
		!hold_r[FLAG_RXACT] |=> flags_r[FLAG_RXACT] == $past(rxact_s);
	endproperty
	a_rxact: assert property (p_rxact) else $error("rx active flag wrong");

	property p_sticky;
		1'b1 |=> (flags_r & $past(kept)) == $past(kept);
	endproperty
	a_sticky: assert property (p_sticky) else $error("held flag lost");

	property p_ep;
		tok_accept |=> ep_r == {1'b1, $past(tok_body[10:7])} &&
			rx_ep[4] == $past(mark_r[tok_body[10:7]]);
	endproperty
	a_ep: assert property (p_ep) else $error("endpoint capture wrong");

	property p_addr;
		tok_valid && !addr_hit && !pkt_start |=> !rx_ep_valid && ep_r == $past(ep_r);
	endproperty
	a_addr: assert property (p_addr) else $error("foreign token passed");

	c_sticky_held: cover property (hold_r[FLAG_TOKEN] && pkt_start && flags_r[FLAG_TOKEN]);
	c_marked_ep:   cover property (rx_ep_valid && rx_ep[4]);
	c_port_a:      cover property (event_port_a ##1 !event_port_a);
endmodule

// file: bench/phy_model.sv
`timescale 1ns/1ps
module phy_model (
	// Clock
	input  wire logic   clk,
	// Transceiver pins
	output logic [5:0]  otg,
	output logic [2:0]  rxl,
	output logic [1:0]  ls,
	output logic        rxact,
	output logic        rxerr,
	// Decoded packets
	output logic        pkt_start,
	output logic [3:0]  pkt_pid,
	output logic        tok_valid,
	output logic [7:0]  tok_pid,
	output logic [15:0] tok_body,
	output logic        crc_err
);
	// Idle line state is SE1 so no line flag follows it
	initial begin
		otg = 6'h00;
		rxl = 3'h0;
		ls = 2'h3;
		rxact = 1'b0;
		rxerr = 1'b0;
		pkt_start = 1'b0;
		pkt_pid = 4'h0;
		tok_valid = 1'b0;
		tok_pid = 8'h00;
		tok_body = 16'h0000;
		crc_err = 1'b0;
	end

	// Sent high bit first, so stored reversed and inverted
	function automatic logic [4:0] crc5(input logic [10:0] d);
		logic [4:0] c;
		c = 5'h1f;
		for (int i = 0; i < 11; i++) begin
			c = {c[3:0], 1'b0} ^ ((c[4] ^ d[i]) ? 5'h05 : 5'h00);
		end
		return {~c[0], ~c[1], ~c[2], ~c[3], ~c[4]};
	endfunction

	// Called at a falling edge; lets one edge pass, holds one cycle, then leaves a changed body
	// Bad bit 0 spoils the CRC5, bit 1 the PID complement
	task automatic send_token(input logic [3:0] pid, input logic [10:0] d, input logic [1:0] bad);
		@(negedge clk);
		tok_pid = {~pid ^ {3'h0, bad[1]}, pid};
		tok_body = {crc5(d) ^ {4'h0, bad[0]}, d};
		tok_valid = 1'b1;
		@(negedge clk);
		tok_valid = 1'b0;
		tok_body = ~tok_body;
	endtask

	task automatic send_pkt(input logic [3:0] pid);
		pkt_pid = pid;
		pkt_start = 1'b1;
		@(negedge clk);
		pkt_start = 1'b0;
		pkt_pid = ~pid;
	endtask

	task automatic send_crc_err();
		crc_err = 1'b1;
		@(negedge clk);
		crc_err = 1'b0;
	endtask

	// Status and line levels as the transceiver shows them
	task automatic set_pins(input logic [5:0] o, input logic [2:0] r, input logic [1:0] l,
		input logic a, input logic e);
		otg = o;
		rxl = r;
		ls = l;
		rxact = a;
		rxerr = e;
	endtask
endmodule

// file: bench/tb.sv
`timescale 1ns/1ps
module tb;
	import usb_frame_pkg::*;
	typedef struct {
		logic [7:0]  a;
		logic [31:0] w;
		logic [31:0] e;
	} row_t;

	logic        clk;
	logic        rst;
	logic [7:0]  reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic [6:0]  dev_addr;
	logic [5:0]  otg;
	logic [2:0]  rxl;
	logic [1:0]  ls;
	logic        rxact;
	logic        rxerr;
	logic        pkt_start;
	logic [3:0]  pkt_pid;
	logic        tok_valid;
	logic [7:0]  tok_pid;
	logic [15:0] tok_body;
	logic        crc_err;
	logic        tx_se0;
	logic        tx_data;
	logic        tx_enable_n;
	logic        fsls_serial;
	logic        ev_a;
	logic        ev_b;
	logic        ev_c;
	logic        ev_d;
	logic [4:0]  rx_ep;
	logic        rx_ep_valid;
	int          bad_count = 0;
	int          cmp_count = 0;
	// Reserved bits, RO places and the unmapped offset are in here
	row_t        rows [9] = '{'{8'h18, 32'hfffffff0, 32'h0}, '{8'h20, 32'hffffffff, 32'h7f},
		'{8'h20, 32'h80, 32'h0}, '{8'h24, 32'h81424314, 32'h81424314},
		'{8'h28, 32'hffffffff, 32'h7ff}, '{8'h34, 32'hffff0008, 32'h8},
		'{8'h38, 32'ha5a5a5a5, 32'ha5a5a5a5}, '{8'h2c, 32'hff, 32'h0}, '{8'h3c, 32'hff, 32'h0}};
	logic [1:0]  codes [3] = '{2'h0, 2'h2, 2'h1};
	logic [31:0] fexp [3] = '{32'h20, 32'h10, 32'h08};

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	phy_model phy (.clk(clk), .otg(otg), .rxl(rxl), .ls(ls), .rxact(rxact), .rxerr(rxerr),
		.pkt_start(pkt_start), .pkt_pid(pkt_pid), .tok_valid(tok_valid), .tok_pid(tok_pid),
		.tok_body(tok_body), .crc_err(crc_err));

	usb_phy_flag_monitor dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.utmi_bvalid(otg[5]), .utmi_idgnd(otg[4]), .utmi_hostdis(otg[3]),
		.utmi_vbusvld(otg[2]), .utmi_sessvld(otg[1]), .utmi_sessend(otg[0]),
		.utmi_rxrcv(rxl[2]), .utmi_rxdm(rxl[1]), .utmi_rxdp(rxl[0]), .utmi_linestate(ls),
		.utmi_rxactive(rxact), .utmi_rxerror(rxerr), .tx_se0(tx_se0), .tx_data(tx_data),
		.tx_enable_n(tx_enable_n), .fsls_serial(fsls_serial), .pkt_start(pkt_start),
		.pkt_pid(pkt_pid), .tok_valid(tok_valid), .tok_pid(tok_pid), .tok_body(tok_body),
		.data_crc_err(crc_err), .dev_addr(dev_addr), .event_port_a(ev_a),
		.event_port_b(ev_b), .event_port_c(ev_c), .event_port_d(ev_d), .rx_ep(rx_ep),
		.rx_ep_valid(rx_ep_valid));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One idle edge first, so back-to-back calls never flip a strobe in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		chk(reg_rdata, e);
	endtask

	task automatic settle();
		repeat (8) @(negedge clk);
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Whole run needs under two hundred cycles
	initial begin
		repeat (2000) @(posedge clk);
		bad_count++;
		$display("Error at %0t: run did not finish", $time);
		complete_run();
	end

	initial begin
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 32'h0;
		dev_addr = 7'h05;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		// Synchroniser leaves reset showing SE0; let the idle line through first
		settle();
		for (logic [7:0] a = 8'h14; a <= 8'h3c; a += 8'h04) begin
			rd(a, (a == 8'h18) ? 32'h2 : 32'h0);
		end
		$display("Test reset values done");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, rows[i].e);
		end
		$display("Test register table done");
		phy.set_pins(6'h2d, 3'h5, 2'h3, 1'b0, 1'b0);
		settle();
		rd(8'h14, 32'h2d);
		rd(8'h18, 32'h50);
		wr(8'h18, 32'hd);
		chk({28'h0, tx_se0, tx_data, tx_enable_n, fsls_serial}, 32'hd);
		wr(8'h18, 32'h2);
		chk({28'h0, tx_se0, tx_data, tx_enable_n, fsls_serial}, 32'h2);
		$display("Test status and serial done");
		wr(8'h24, 32'h03081020);
		for (int i = 0; i < 3; i++) begin
			phy.set_pins(6'h2d, 3'h5, codes[i], 1'b0, 1'b0);
			settle();
			rd(8'h1c, fexp[i]);
			chk({28'h0, ev_d, ev_c, ev_b, ev_a}, 32'h1 << i);
		end
		phy.set_pins(6'h2d, 3'h5, 2'h3, 1'b1, 1'b1);
		settle();
		rd(8'h1c, 32'h03);
		chk({28'h0, ev_d, ev_c, ev_b, ev_a}, 32'h8);
		phy.set_pins(6'h2d, 3'h5, 2'h3, 1'b0, 1'b0);
		settle();
		rd(8'h1c, 32'h0);
		$display("Test line flags done");
		phy.send_token(4'h9, {4'h3, 7'h05}, 2'h0);
		chk({26'h0, rx_ep_valid, rx_ep}, 32'h33);
		@(negedge clk);
		chk({26'h0, rx_ep_valid, rx_ep}, 32'h13);
		rd(8'h30, 32'h13);
		rd(8'h1c, 32'h40);
		phy.send_token(4'h9, {4'h3, 7'h05}, 2'h1);
		chk({26'h0, rx_ep_valid, rx_ep}, 32'h13);
		phy.send_token(4'h9, {4'h3, 7'h05}, 2'h2);
		chk({26'h0, rx_ep_valid, rx_ep}, 32'h13);
		phy.send_token(4'h9, {4'h3, 7'h06}, 2'h0);
		chk({26'h0, rx_ep_valid, rx_ep}, 32'h13);
		phy.send_token(4'h9, {4'h2, 7'h05}, 2'h0);
		chk({26'h0, rx_ep_valid, rx_ep}, 32'h22);
		phy.send_pkt(4'h3);
		rd(8'h2c, 32'h3);
		rd(8'h1c, 32'h0);
		$display("Test tokens done");
		wr(8'h20, 32'h44);
		phy.send_crc_err();
		rd(8'h1c, 32'h04);
		phy.send_token(4'h9, {4'h2, 7'h05}, 2'h0);
		phy.send_pkt(4'h1);
		rd(8'h1c, 32'h44);
		wr(8'h1c, 32'h40);
		rd(8'h1c, 32'h04);
		wr(8'h20, 32'h0);
		phy.send_pkt(4'h1);
		rd(8'h1c, 32'h0);
		$display("Test hold flags done");
		phy.send_token(4'h5, 11'h123, 2'h0);
		rd(8'h28, 32'h123);
		wr(8'h18, 32'hd);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		chk({28'h0, tx_se0, tx_data, tx_enable_n, fsls_serial}, 32'h2);
		rst = 1'b0;
		@(negedge clk);
		rd(8'h28, 32'h0);
		$display("Test frame and second reset done");
		complete_run();
	end
endmodule
